// ==== tccr_pkg.sv ====
// Constants, register map and carrier types of the timer common control section.
// Assumes a 32-bit Avalon-MM slave port on core_clk; one register per aligned word.
//
// Functional notes
// - each general register is 16 bits, used for compare or capture
// - channels 0, 3, 4 have registers A-D; channels 1, 2 have A, B
// - channels 0, 3, 4: C buffers A, D buffers B when enabled
// - general registers load ffff on init; manual reset leaves them
// - run bits: 0-2 for channels 0-2, 6 for channel 3, 7 for channel 4
// - run register clears to 00 on init, kept over manual reset
// - clearing run with pin in output mode holds the compare level
// - pin config write while halted drives pin to its initial level
// - in the two PWM modes, clearing run returns pin to initial level
// - bits 5-3 of run and lockstep registers read 0, written 0
// - lockstep register has one select bit per channel, same positions
// - select 0: independent preset/clear; 1: joins synchronous preset/clear
// - synchronous clear needs the clear-source field set as well
// - lockstep register clears to 00 on init, kept over manual reset
// - six motor pins give no timer output unless their gate bit is set
// - gate register loads c0 on init, kept over manual reset
// - gate register bits 7 and 6 always read 1, written 1
// - gate bits 5-0: ch4 D, ch4 C, ch3 D, ch4 B, ch4 A, ch3 B
// - channel counters are 16 bits, clear to 0000 on init

package tccr_pkg;

  localparam int unsigned TCCR_NUM_GEN = 16;
  localparam int unsigned TCCR_NUM_CH = 5;
  localparam int unsigned TCCR_NUM_GATE = 6;

  // reset values
  localparam logic [15:0] TCCR_GEN_RESET = 16'hffff;
  localparam logic [15:0] TCCR_CNT_RESET = 16'h0000;
  localparam logic [7:0] TCCR_RUN_RESET = 8'h00;
  localparam logic [7:0] TCCR_SYNC_RESET = 8'h00;
  localparam logic [7:0] TCCR_GATE_RESET = 8'hc0;
  localparam logic [5:0] TCCR_BUFEN_RESET = 6'h00;

  // field layouts
  localparam logic [7:0] TCCR_CH_BIT_MASK = 8'hc7;
  localparam logic [7:0] TCCR_GATE_FIXED = 8'hc0;
  localparam logic [4:0][2:0] TCCR_CH_POS = {3'h7, 3'h6, 3'h2, 3'h1, 3'h0};

  // owning channel of each general register, index 15 first
  localparam logic [15:0][2:0] TCCR_GEN_CH = {3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3,
                                              3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
  // general register gated by each gate bit, bit 5 first
  localparam logic [5:0][3:0] TCCR_GATE_PIN = {4'hf, 4'he, 4'hb, 4'hd, 4'hc, 4'h9};
  // buffer pairs: main register, buffer register, channel
  localparam logic [5:0][3:0] TCCR_BUF_MAIN = {4'hd, 4'hc, 4'h9, 4'h8, 4'h1, 4'h0};
  localparam logic [5:0][3:0] TCCR_BUF_SRC = {4'hf, 4'he, 4'hb, 4'ha, 4'h3, 4'h2};
  localparam logic [5:0][2:0] TCCR_BUF_CH = {3'h4, 3'h4, 3'h3, 3'h3, 3'h0, 3'h0};

  // byte offsets on the bus
  localparam logic [7:0] TCCR_OFF_GEN_BASE = 8'h00;
  localparam logic [7:0] TCCR_OFF_RUN = 8'h40;
  localparam logic [7:0] TCCR_OFF_SYNC = 8'h44;
  localparam logic [7:0] TCCR_OFF_GATE = 8'h48;
  localparam logic [7:0] TCCR_OFF_BUFEN = 8'h4c;
  localparam logic [7:0] TCCR_OFF_CNT_BASE = 8'h50;
  localparam logic [7:0] TCCR_OFF_CNT_LAST = 8'h60;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tccr_avm_req_t;

  typedef struct packed {
    logic [15:0] output_mode;
    logic [15:0] init_level;
    logic [15:0] cmp_level;
    logic [4:0] cfg_write;
    logic [4:0] pwm_mode;
  } tccr_pin_in_t;

  typedef struct packed {
    logic [15:0] capture;
    logic [4:0] buf_xfer;
    logic [4:0] count_tick;
    logic [4:0] clear_event;
    logic [4:0] clear_src_set;
  } tccr_evt_t;

  typedef struct packed {
    logic [15:0][15:0] gen;
    logic [4:0][15:0] cnt;
    logic [7:0] run;
    logic [7:0] sync;
    logic [7:0] gate;
    logic [5:0] bufen;
    logic [4:0] prev_run;
    logic [15:0] pin_level;
    logic [15:0] cmp_match;
    logic [5:0] drive_en;
    logic wait_req;
    logic [31:0] rdata;
  } tccr_state_t;

endpackage : tccr_pkg

// ==== tccr_ctrl.sv ====
// Common control section: general registers, channel counters, run, lockstep and gate bits.
// Assumes an Avalon-MM master on core_clk and pin/clear logic outside driving the event inputs.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tccr_ctrl
  import tccr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire tccr_avm_req_t avm_req,
  output logic avm_waitrequest,
  output logic [31:0] avm_readdata,
  input wire tccr_pin_in_t pin_in,
  input wire tccr_evt_t evt_in,
  output logic [4:0] count_enable,
  output logic [4:0] lockstep_sel,
  output logic [4:0][15:0] counter_value,
  output logic [15:0] compare_match,
  output logic [15:0] pin_level,
  output logic [5:0] pin_drive_en
);

  tccr_state_t s;
  tccr_state_t next_s;

  logic req;
  logic wr;
  logic [5:0] idx;
  logic [4:0] run_ch;
  logic [4:0] sync_ch;
  logic [4:0] cnt_hit;
  logic sync_preset;
  logic sync_clear;

  // read mux; unmapped words read zero
  function automatic logic [31:0] tccr_read(input logic [7:0] addr, input tccr_state_t st);
    logic [31:0] v;
    logic [7:0] coff;
    v = 32'h0000_0000;
    // counters sit at 0x50, so index from that base, not from raw address bits
    coff = addr - TCCR_OFF_CNT_BASE;
    if (addr < TCCR_OFF_RUN) begin
      v = {16'h0000, st.gen[addr[5:2]]};
    end else if (addr == TCCR_OFF_RUN) begin
      v = {24'h00_0000, st.run & TCCR_CH_BIT_MASK};
    end else if (addr == TCCR_OFF_SYNC) begin
      v = {24'h00_0000, st.sync & TCCR_CH_BIT_MASK};
    end else if (addr == TCCR_OFF_GATE) begin
      v = {24'h00_0000, st.gate | TCCR_GATE_FIXED};
    end else if (addr == TCCR_OFF_BUFEN) begin
      v = {26'h000_0000, st.bufen};
    end else if (addr >= TCCR_OFF_CNT_BASE && addr <= TCCR_OFF_CNT_LAST) begin
      v = {16'h0000, st.cnt[coff[4:2]]};
    end
    return v;
  endfunction : tccr_read

  // outputs are fields of the state register
  assign avm_waitrequest = s.wait_req;
  assign avm_readdata = s.rdata;
  assign counter_value = s.cnt;
  assign compare_match = s.cmp_match;
  assign pin_level = s.pin_level;
  assign pin_drive_en = s.drive_en;
  always_comb begin
    for (int c = 0; c < TCCR_NUM_CH; c++) begin
      count_enable[c] = s.run[TCCR_CH_POS[c]];
      lockstep_sel[c] = s.sync[TCCR_CH_POS[c]];
    end
  end

  // next-state logic for the whole block
  always_comb begin
    next_s = s;
    req = avm_req.read || avm_req.write;
    // one wait cycle, then the access completes with waitrequest low
    next_s.wait_req = !(req && s.wait_req);
    wr = avm_req.write && !s.wait_req;
    idx = avm_req.address[7:2];
    if (req && s.wait_req) begin
      next_s.rdata = tccr_read(avm_req.address, s);
    end

    // per-channel run and select bits, and preset/clear decode
    for (int c = 0; c < TCCR_NUM_CH; c++) begin
      run_ch[c] = s.run[TCCR_CH_POS[c]];
      sync_ch[c] = s.sync[TCCR_CH_POS[c]];
      cnt_hit[c] = wr && (avm_req.address == TCCR_OFF_CNT_BASE + 8'(4 * c))
                   && (avm_req.byteenable[1:0] == 2'b11);
    end
    sync_preset = |(cnt_hit & sync_ch);
    // a clear only spreads if the source channel has its clear source set
    sync_clear = |(sync_ch & evt_in.clear_event & evt_in.clear_src_set);

    // counters: bus preset over clear over counting
    for (int c = 0; c < TCCR_NUM_CH; c++) begin
      next_s.prev_run[c] = run_ch[c];
      if (cnt_hit[c] || (sync_preset && sync_ch[c])) begin
        next_s.cnt[c] = avm_req.writedata[15:0];
      end else if ((evt_in.clear_event[c] && evt_in.clear_src_set[c])
                   || (sync_ch[c] && sync_clear)) begin
        next_s.cnt[c] = TCCR_CNT_RESET;
      end else if (run_ch[c] && evt_in.count_tick[c]) begin
        next_s.cnt[c] = s.cnt[c] + 16'h0001;
      end
    end

    // general registers: full 16-bit write, else capture of the counter
    for (int i = 0; i < TCCR_NUM_GEN; i++) begin
      if (wr && idx == 6'(i) && avm_req.byteenable[1:0] == 2'b11) begin
        next_s.gen[i] = avm_req.writedata[15:0];
      end else if (evt_in.capture[i]) begin
        next_s.gen[i] = s.cnt[TCCR_GEN_CH[i]];
      end
      next_s.cmp_match[i] = run_ch[TCCR_GEN_CH[i]]
                            && (s.cnt[TCCR_GEN_CH[i]] == s.gen[i]);
    end

    // buffer pairs: transfer into the main register, capture pushes old value back
    for (int k = 0; k < TCCR_NUM_GATE; k++) begin
      if (s.bufen[k] && evt_in.buf_xfer[TCCR_BUF_CH[k]]) begin
        next_s.gen[TCCR_BUF_MAIN[k]] = s.gen[TCCR_BUF_SRC[k]];
      end
      if (s.bufen[k] && evt_in.capture[TCCR_BUF_MAIN[k]]) begin
        next_s.gen[TCCR_BUF_SRC[k]] = s.gen[TCCR_BUF_MAIN[k]];
      end
    end

    // byte registers need lane 0; reserved bits forced on the way in
    if (wr && avm_req.byteenable[0]) begin
      if (avm_req.address == TCCR_OFF_RUN) begin
        next_s.run = avm_req.writedata[7:0] & TCCR_CH_BIT_MASK;
      end
      if (avm_req.address == TCCR_OFF_SYNC) begin
        next_s.sync = avm_req.writedata[7:0] & TCCR_CH_BIT_MASK;
      end
      if (avm_req.address == TCCR_OFF_GATE) begin
        next_s.gate = avm_req.writedata[7:0] | TCCR_GATE_FIXED;
      end
      if (avm_req.address == TCCR_OFF_BUFEN) begin
        next_s.bufen = avm_req.writedata[5:0];
      end
    end

    // pin levels: follow compare while running, else hold or reload initial
    for (int i = 0; i < TCCR_NUM_GEN; i++) begin
      if (run_ch[TCCR_GEN_CH[i]]) begin
        next_s.pin_level[i] = pin_in.cmp_level[i];
      end else if (pin_in.cfg_write[TCCR_GEN_CH[i]]) begin
        next_s.pin_level[i] = pin_in.init_level[i];
      end else if (s.prev_run[TCCR_GEN_CH[i]] && pin_in.pwm_mode[TCCR_GEN_CH[i]]
                   && pin_in.output_mode[i]) begin
        next_s.pin_level[i] = pin_in.init_level[i];
      end else begin
        next_s.pin_level[i] = s.pin_level[i];
      end
    end

    // motor pins drive only with their gate bit set
    for (int k = 0; k < TCCR_NUM_GATE; k++) begin
      next_s.drive_en[k] = s.gate[k] && pin_in.output_mode[TCCR_GATE_PIN[k]];
    end
  end

  // rst is the combined power-on/standby init; no manual reset reaches this block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.gen <= {TCCR_NUM_GEN{TCCR_GEN_RESET}};
      s.cnt <= {TCCR_NUM_CH{TCCR_CNT_RESET}};
      s.run <= TCCR_RUN_RESET;
      s.sync <= TCCR_SYNC_RESET;
      s.gate <= TCCR_GATE_RESET;
      s.bufen <= TCCR_BUFEN_RESET;
      s.wait_req <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_run_reserved;
    s.run[5:3] == 3'h0 && s.sync[5:3] == 3'h0;
  endproperty
  a_run_reserved: assert property (p_run_reserved) else $error("reserved bits set");

  property p_gate_top;
    s.gate[7:6] == 2'b11;
  endproperty
  a_gate_top: assert property (p_gate_top) else $error("gate top bits not one");

  property p_run_write;
    (avm_req.write && !s.wait_req && avm_req.address == TCCR_OFF_RUN && avm_req.byteenable[0])
      |=> count_enable == {$past(avm_req.writedata[7:6]), $past(avm_req.writedata[2:0])};
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bits not written");

  property p_halt_hold;
    ($past(s.run[0]) && !s.run[0] && !pin_in.pwm_mode[0] && !pin_in.cfg_write[0])
      |=> pin_level[0] == $past(pin_level[0]);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted pin level moved");

  property p_cfg_init;
    (!s.run[0] && pin_in.cfg_write[0]) |=> pin_level[1] == $past(pin_in.init_level[1]);
  endproperty
  a_cfg_init: assert property (p_cfg_init) else $error("initial level not driven");

  property p_pwm_return;
    (!s.run[6] && s.prev_run[3] && pin_in.pwm_mode[3] && pin_in.output_mode[9]
     && !pin_in.cfg_write[3]) |=> pin_level[9] == $past(pin_in.init_level[9]);
  endproperty
  a_pwm_return: assert property (p_pwm_return) else $error("pwm pin not reset");

  property p_gate_off;
    !s.gate[0] |=> !pin_drive_en[0] ##1 (s.gate[0] || !pin_drive_en[0]);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("ungated pin driving");

  property p_byte_refuse;
    (avm_req.write && !s.wait_req && avm_req.address < TCCR_OFF_RUN
     && avm_req.byteenable[1:0] != 2'b11 && evt_in.capture == 16'h0000
     && evt_in.buf_xfer == 5'h00) |=> s.gen == $past(s.gen);
  endproperty
  a_byte_refuse: assert property (p_byte_refuse) else $error("partial write hit register");

  property p_sync_clear;
    (s.sync[0] && s.sync[1] && evt_in.clear_event[1] && evt_in.clear_src_set[1]
     && !(avm_req.write && !s.wait_req)) |=> counter_value[0] == 16'h0000;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("lockstep clear missed");

  property p_buffer_xfer;
    (s.bufen[0] && evt_in.buf_xfer[0] && !(avm_req.write && !s.wait_req)
     && evt_in.capture[0] == 1'b0) |=> s.gen[0] == $past(s.gen[2]);
  endproperty
  a_buffer_xfer: assert property (p_buffer_xfer) else $error("buffer transfer missed");

  property p_compare;
    (s.run[0] && s.cnt[0] == s.gen[0]) |=> compare_match[0];
  endproperty
  a_compare: assert property (p_compare) else $error("compare match missed");

  property p_wait_one;
    (req && s.wait_req) |=> !avm_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("slave did not answer");

  // bus handshake: idle keeps wait high, the answer lasts one cycle only
  property p_wait_idle;
    !req |=> avm_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait dropped while idle");

  property p_wait_pulse;
    !avm_waitrequest |=> avm_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");

  // read data shape: reserved and upper bits fixed whatever the state
  property p_read_run;
    (avm_req.read && s.wait_req && avm_req.address == TCCR_OFF_RUN)
      |=> avm_readdata[31:8] == 24'h00_0000 && avm_readdata[5:3] == 3'h0;
  endproperty
  a_read_run: assert property (p_read_run) else $error("run reserved bits read one");

  property p_read_gate;
    (avm_req.read && s.wait_req && avm_req.address == TCCR_OFF_GATE)
      |=> avm_readdata[7:6] == 2'b11;
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("gate top bits read zero");

  property p_read_gen;
    (avm_req.read && s.wait_req && avm_req.address < TCCR_OFF_RUN)
      |=> avm_readdata[31:16] == 16'h0000;
  endproperty
  a_read_gen: assert property (p_read_gen) else $error("general read too wide");

  property p_read_unmapped;
    (avm_req.read && s.wait_req && avm_req.address > TCCR_OFF_CNT_LAST)
      |=> avm_readdata == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read nonzero");

  // register writes land as written
  property p_sync_write;
    (wr && avm_req.address == TCCR_OFF_SYNC && avm_req.byteenable[0])
      |=> lockstep_sel == {$past(avm_req.writedata[7:6]), $past(avm_req.writedata[2:0])};
  endproperty
  a_sync_write: assert property (p_sync_write) else $error("select bits not written");

  property p_gate_write;
    (wr && avm_req.address == TCCR_OFF_GATE && avm_req.byteenable[0])
      |=> s.gate[5:0] == $past(avm_req.writedata[5:0]);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate bits not written");

  // a buffer transfer or capture would overwrite the word, so keep them out
  property p_gen_write;
    (wr && avm_req.address < TCCR_OFF_RUN && avm_req.byteenable[1:0] == 2'b11
     && evt_in.capture == 16'h0000 && evt_in.buf_xfer == 5'h00)
      |=> s.gen[$past(avm_req.address[5:2])] == $past(avm_req.writedata[15:0]);
  endproperty
  a_gen_write: assert property (p_gen_write) else $error("general write lost");

  property p_capture;
    (evt_in.capture[5] && !wr) |=> s.gen[5] == $past(s.cnt[1]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_buf_push;
    (s.bufen[1] && evt_in.capture[1] && !wr) |=> s.gen[3] == $past(s.gen[1]);
  endproperty
  a_buf_push: assert property (p_buf_push) else $error("buffer not refilled");

  // counters: hold when halted, step when running, byte writes refused
  property p_cnt_halt;
    (!s.run[0] && !wr && evt_in.clear_event == 5'h00)
      |=> counter_value[0] == $past(counter_value[0]);
  endproperty
  a_cnt_halt: assert property (p_cnt_halt) else $error("halted counter moved");

  property p_cnt_step;
    (s.run[0] && evt_in.count_tick[0] && !wr && evt_in.clear_event == 5'h00)
      |=> counter_value[0] == $past(counter_value[0]) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("running counter stuck");

  property p_cnt_byte;
    (wr && avm_req.address == TCCR_OFF_CNT_BASE + 8'h08 && avm_req.byteenable[1:0] != 2'b11
     && !s.run[2] && evt_in.clear_event == 5'h00)
      |=> counter_value[2] == $past(counter_value[2]);
  endproperty
  a_cnt_byte: assert property (p_cnt_byte) else $error("partial counter write");

  // clear sources and lockstep spreading
  property p_own_clear;
    (evt_in.clear_event[2] && evt_in.clear_src_set[2] && !wr) |=> counter_value[2] == 16'h0000;
  endproperty
  a_own_clear: assert property (p_own_clear) else $error("own clear missed");

  property p_no_src;
    (!s.sync[2] && !s.run[2] && evt_in.clear_event[2] && !evt_in.clear_src_set[2] && !wr)
      |=> counter_value[2] == $past(counter_value[2]);
  endproperty
  a_no_src: assert property (p_no_src) else $error("clear without source");

  property p_indep;
    (!s.sync[2] && !s.run[2] && evt_in.clear_event[2] == 1'b0
     && !(wr && avm_req.address == TCCR_OFF_CNT_BASE + 8'h08))
      |=> counter_value[2] == $past(counter_value[2]);
  endproperty
  a_indep: assert property (p_indep) else $error("independent counter disturbed");

  property p_sync_preset;
    (s.sync[0] && s.sync[1] && wr && avm_req.address == TCCR_OFF_CNT_BASE
     && avm_req.byteenable[1:0] == 2'b11) |=> counter_value[1] == $past(avm_req.writedata[15:0]);
  endproperty
  a_sync_preset: assert property (p_sync_preset) else $error("lockstep preset missed");

  // pins and compare while running and halted
  property p_pin_run;
    s.run[0] |=> pin_level[0] == $past(pin_in.cmp_level[0]);
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("running pin off compare");

  property p_cmp_stop;
    !s.run[0] |=> !compare_match[0];
  endproperty
  a_cmp_stop: assert property (p_cmp_stop) else $error("halted compare fired");

  property p_drive_on;
    (s.gate[1] && pin_in.output_mode[12]) |=> pin_drive_en[1];
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("gated pin not driving");

endmodule : tccr_ctrl

`default_nettype wire

// ==== tccr_far_model.sv ====
// far-side model: pin configuration and event sources seen by the control section.
// assumes the bench raises its requests by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
`default_nettype none

module tccr_far_model
  import tccr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] clr_req,
  input wire logic [4:0] cfg_req,
  input wire logic [15:0] omode,
  input wire logic [4:0] xfer_req,
  input wire logic [4:0] pwm_req,
  output var tccr_pin_in_t pin_in,
  output var tccr_evt_t evt_in
);
  // one registered stage, as pin logic clocked off the same edge would be
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_in <= '0;
      evt_in <= '0;
    end else begin
      pin_in.output_mode <= omode;
      pin_in.init_level <= 16'h5a5a; // unlike the compare level, so a swap shows
      pin_in.cmp_level <= 16'ha5a5;
      pin_in.cfg_write <= cfg_req; // bench sets the gate first
      pin_in.pwm_mode <= pwm_req;
      evt_in.capture <= 16'h0000;
      evt_in.buf_xfer <= xfer_req;
      evt_in.count_tick <= 5'h1f; // full-rate prescaler
      evt_in.clear_event <= clr_req;
      evt_in.clear_src_set <= 5'h1f;
    end
  end
endmodule : tccr_far_model

`default_nettype wire

// ==== timer_common_control_regs_tb_top.sv ====
// self-checking bench for the common control section.
// assumes the far-side model drives pins and events; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none

module timer_common_control_regs_tb_top;
  import tccr_pkg::*;
  logic core_clk;
  logic rst;
  tccr_avm_req_t req;
  logic waitrequest;
  logic [31:0] readdata;
  tccr_pin_in_t pin_in;
  tccr_evt_t evt_in;
  logic [4:0] clr_req;
  logic [4:0] cfg_req;
  logic [15:0] omode;
  logic [4:0] xfer_req;
  logic [4:0] pwm_req;
  logic [4:0] count_enable;
  logic [4:0] lockstep_sel;
  logic [4:0][15:0] counter_value;
  logic [15:0] pin_level;
  logic [5:0] pin_drive_en;
  int error_cnt;
  int total_checks;

  tccr_ctrl dut_u (.core_clk(core_clk), .rst(rst), .avm_req(req),
    .avm_waitrequest(waitrequest), .avm_readdata(readdata), .pin_in(pin_in),
    .evt_in(evt_in), .count_enable(count_enable), .lockstep_sel(lockstep_sel),
    .counter_value(counter_value), .compare_match(), .pin_level(pin_level),
    .pin_drive_en(pin_drive_en));
  tccr_far_model far_u (.core_clk(core_clk), .rst(rst), .clr_req(clr_req),
    .cfg_req(cfg_req), .omode(omode), .xfer_req(xfer_req), .pwm_req(pwm_req),
    .pin_in(pin_in), .evt_in(evt_in));

  // 125 MHz
  always #4 core_clk = ~core_clk;

  task results;
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one bus cycle; entered just after a rising edge, leaves one idle edge behind
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= be;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        chk(32'h0, 32'h1);
        results;
      end
      @(posedge core_clk);
    end
    q = readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask : rd

  // reset values, read back after each init
  task automatic init_vals;
    for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'hffff);
    for (int i = 0; i < 5; i++) rd(8'(8'h50 + i * 4), 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'hc0);
  endtask : init_vals

  initial begin
    logic [31:0] v;
    logic [31:0] q;
    core_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    clr_req = 5'h00;
    cfg_req = 5'h00;
    omode = 16'hffff;
    xfer_req = 5'h00;
    pwm_req = 5'h00;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(97));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    init_vals;
    // full 16-bit data kept; byte-lane writes refused
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      wr(8'(i * 4), v);
      bus(1'b1, 8'(i * 4), ~v, 4'h1, q);
      rd(8'(i * 4), {16'h0, v[15:0]});
    end
    rd(8'h80, 32'h0);
    // ch0 buffer: C moves into A on a transfer event
    wr(8'h4c, 32'h01);
    rd(8'h4c, 32'h01);
    v = $urandom;
    wr(8'h08, v);
    xfer_req <= 5'h01;
    @(posedge core_clk);
    xfer_req <= 5'h00;
    repeat (3) @(posedge core_clk);
    rd(8'h00, {16'h0, v[15:0]});
    wr(8'h4c, 32'h0);
    // gate: fixed top bits, one pin at a time
    wr(8'h48, 32'h0);
    rd(8'h48, 32'hc0);
    @(negedge core_clk);
    chk({26'h0, pin_drive_en}, 32'h0);
    @(posedge core_clk);
    for (int k = 0; k < 6; k++) begin
      wr(8'h48, 32'h1 << k);
      @(negedge core_clk);
      chk({26'h0, pin_drive_en}, 32'h1 << k);
      @(posedge core_clk);
    end
    wr(8'h44, 32'hff);
    rd(8'h44, 32'hc7);
    @(negedge core_clk);
    chk({27'h0, lockstep_sel}, 32'h1f);
    @(posedge core_clk);
    // lockstep on ch0 and ch1 only: preset and clear spread, ch2 untouched
    wr(8'h44, 32'h03);
    wr(8'h50, 32'h1234);
    rd(8'h54, 32'h1234);
    rd(8'h58, 32'h0);
    clr_req <= 5'h02;
    @(posedge core_clk);
    clr_req <= 5'h00;
    repeat (3) @(posedge core_clk);
    rd(8'h50, 32'h0);
    // halted pin config loads the initial level
    cfg_req <= 5'h01;
    @(posedge core_clk);
    cfg_req <= 5'h00;
    repeat (3) @(negedge core_clk);
    chk({28'h0, pin_level[3:0]}, 32'ha);
    @(posedge core_clk);
    wr(8'h40, 32'h39);
    rd(8'h40, 32'h01);
    bus(1'b0, 8'h50, 32'h0, 4'hf, q);
    chk({31'h0, q != 32'h0}, 32'h1);
    @(negedge core_clk);
    chk({27'h0, count_enable}, 32'h01);
    chk({28'h0, pin_level[3:0]}, 32'h5);
    @(posedge core_clk);
    // halt: counter frozen, compare level held
    wr(8'h40, 32'h0);
    v = {16'h0, 16'($urandom)};
    wr(8'h50, v);
    repeat (10) @(posedge core_clk);
    rd(8'h50, v);
    @(negedge core_clk);
    chk({28'h0, pin_level[3:0]}, 32'h5);
    @(posedge core_clk);
    // ch3 in pwm mode: halting returns pin B to its initial level
    pwm_req <= 5'h08;
    wr(8'h40, 32'h40);
    @(negedge core_clk);
    chk({31'h0, pin_level[9]}, 32'h0);
    @(posedge core_clk);
    wr(8'h40, 32'h0);
    @(negedge core_clk);
    chk({31'h0, pin_level[9]}, 32'h1);
    @(posedge core_clk);
    pwm_req <= 5'h00;
    // second init with all channels halted
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    init_vals;
    results;
  end
endmodule : timer_common_control_regs_tb_top

`default_nettype wire
